// file: ebbc_pkg.sv
/*
  Constants for the endpoint buffer byte-count bank: register offsets,
  field positions, reset values, buffer base addresses and full lengths.
  Assumes an 8-bit register port with byte offsets as printed.
*/
package ebbc_pkg;
  localparam logic [7:0] EBBC_OFS_EP_ONE_TX_COUNT = 8'hc7;
  localparam logic [7:0] EBBC_OFS_A_WR_HIGH = 8'hce;
  localparam logic [7:0] EBBC_OFS_A_WR_LOW = 8'hcf;
  localparam logic [7:0] EBBC_OFS_B_WR_HIGH = 8'hd1;
  localparam logic [7:0] EBBC_OFS_B_WR_LOW = 8'hd2;
  localparam logic [7:0] EBBC_OFS_A_RD_HIGH = 8'hd3;
  localparam logic [7:0] EBBC_OFS_A_RD_LOW = 8'hd4;

  localparam logic [7:0] EBBC_RESET_VAL = 8'h00;

  // Field positions
  localparam int EBBC_TX_FULL_BIT = 6;
  localparam int EBBC_HIGH_FULL_BIT = 1;
  localparam int EBBC_HIGH_MSB_BIT = 0;

  // Writable masks; every other bit reads zero
  localparam logic [7:0] EBBC_TX_COUNT_MASK = 8'h7f;
  localparam logic [7:0] EBBC_HIGH_MASK = 8'h03;

  // Packet and buffer sizes
  localparam int EBBC_TX_CNT_W = 6;
  localparam int EBBC_TX_LEN_W = 7;
  localparam logic [6:0] EBBC_TX_FULL_LEN = 7'h40;
  localparam int EBBC_BUF_CNT_W = 9;
  localparam int EBBC_BUF_LEN_W = 10;
  localparam logic [9:0] EBBC_BUF_FULL_LEN = 10'h200;

  // Buffer base addresses in packet SRAM
  localparam logic [15:0] EBBC_EP_ONE_TX_BASE = 16'h00c0;
  localparam logic [15:0] EBBC_BUF_A_BASE = 16'h0100;
  localparam logic [15:0] EBBC_BUF_B_BASE = 16'h0300;
endpackage : ebbc_pkg

// file: ebbc_cnt_if.sv
/*
  Carrier between the bank and one write-count capture unit: a completed
  transfer report in, the two register images out.
  Assumes one clock shared by both ends.
*/
interface ebbc_cnt_if;
  import ebbc_pkg::*;
  logic done;
  logic [EBBC_BUF_LEN_W-1:0] bytes;
  logic [7:0] high;
  logic [7:0] low;
  modport bank (output done, output bytes, input high, input low);
  modport unit (input done, input bytes, output high, output low);
endinterface : ebbc_cnt_if

// file: ebbc_len_decode.sv
/*
  Effective length from a count field and a full-size flag.
  Assumes FULL_LEN fits LEN_W bits and the count is narrower than LEN_W.
*/
module ebbc_len_decode
  import ebbc_pkg::*;
#(
  parameter int CNT_W = 9,
  parameter int LEN_W = 10,
  parameter logic [LEN_W-1:0] FULL_LEN = 10'h200
) (
  input wire logic full_flag,
  input wire logic [CNT_W-1:0] count,
  output logic [LEN_W-1:0] length
);
  if (CNT_W >= LEN_W) begin : g_bad_width
    $error("ebbc_len_decode: count must be narrower than length");
  end

  // Flag overrides whatever the count bits hold
  always_comb begin
    if (full_flag) begin
      length = FULL_LEN; // [R12] [R2] [R9]
    end else begin
      length = {{(LEN_W-CNT_W){1'b0}}, count}; // [R12] [R10]
    end
  end
endmodule : ebbc_len_decode

// file: ebbc_wr_count.sv
/*
  Captures the byte count of a completed write into one bulk buffer and
  presents it as the high and low read-only register images.
  Assumes done is a one-cycle pulse on the bank clock with bytes beside it.
*/
module ebbc_wr_count
  import ebbc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  ebbc_cnt_if.unit cnt
);
  logic full_q;
  logic msb_q;
  logic [7:0] low_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      full_q <= 1'b0;
      msb_q <= 1'b0;
      low_q <= EBBC_RESET_VAL;
    end else if (cnt.done) begin
      full_q <= (cnt.bytes == EBBC_BUF_FULL_LEN); // [R5]
      msb_q <= cnt.bytes[8]; // [R6]
      low_q <= cnt.bytes[7:0]; // [R7] [R8]
    end
  end

  // Upper six bits are reserved and read zero
  assign cnt.high = {6'h00, full_q, msb_q}; // [R4]
  assign cnt.low = low_q;
endmodule : ebbc_wr_count

// file: ebbc_top.sv
/*
  Byte-count register bank for the endpoint-one transmit buffer and bulk
  buffers A and B. Firmware reaches it over a plain 8-bit register port;
  the USB engine, on the same clock, reports completed writes and picks
  up transmit and read-out lengths.
  Assumes engine inputs are synchronous to clk and need no synchroniser.
*/
// Implementation choice: the strobed register port.
// Functional notes
// [R1] Six-bit count sets endpoint-one packet length
// [R2] Full-packet flag means 64-byte packet
// [R3] Cleared count plus transmit sends empty packet
// [R4] Reserved bits read zero, ignore writes
// [R5] Full-buffer flag set on exactly 512 bytes
// [R6] Received count bit 8 in bit 0
// [R7] Buffer A low write count readable
// [R8] Buffer B low write count readable
// [R9] Firmware full-buffer flag requests 512-byte read
// [R10] Firmware bit 8 joins read low count
// [R11] Low read count sets buffer A fetch
// [R12] Length is nine-bit count, or 512 when flagged
module ebbc_top
  import ebbc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ep_one_tx_go,
  output logic ep_one_tx_start,
  output logic [EBBC_TX_LEN_W-1:0] ep_one_tx_len,
  output logic [15:0] ep_one_tx_base,
  input wire logic buf_a_wr_done,
  input wire logic [EBBC_BUF_LEN_W-1:0] buf_a_wr_bytes,
  input wire logic buf_b_wr_done,
  input wire logic [EBBC_BUF_LEN_W-1:0] buf_b_wr_bytes,
  output logic [EBBC_BUF_LEN_W-1:0] buf_a_rd_len,
  output logic [15:0] buf_a_rd_base
);
  logic [7:0] tx_count_q;
  logic [7:0] rd_high_q;
  logic [7:0] rd_low_q;
  logic [7:0] rdata_d;
  logic [EBBC_TX_LEN_W-1:0] tx_len_d;
  logic [EBBC_BUF_LEN_W-1:0] rd_len_d;

  ebbc_cnt_if cnt_u [2] ();

  assign cnt_u[0].done = buf_a_wr_done;
  assign cnt_u[0].bytes = buf_a_wr_bytes;
  assign cnt_u[1].done = buf_b_wr_done;
  assign cnt_u[1].bytes = buf_b_wr_bytes;

  // One capture unit per bulk buffer: index 0 is A, 1 is B
  for (genvar g = 0; g < 2; g++) begin : g_wr
    ebbc_wr_count u_wr (
      .clk(clk),
      .reset_n(reset_n),
      .cnt(cnt_u[g].unit)
    );
  end

  // Firmware-writable count registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_count_q <= EBBC_RESET_VAL;
    end else if (reg_wr && reg_addr == EBBC_OFS_EP_ONE_TX_COUNT) begin
      tx_count_q <= reg_wdata & EBBC_TX_COUNT_MASK; // [R4] [R1] [R2] [R3]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_high_q <= EBBC_RESET_VAL;
    end else if (reg_wr && reg_addr == EBBC_OFS_A_RD_HIGH) begin
      rd_high_q <= reg_wdata & EBBC_HIGH_MASK; // [R4] [R9] [R10]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_low_q <= EBBC_RESET_VAL;
    end else if (reg_wr && reg_addr == EBBC_OFS_A_RD_LOW) begin
      rd_low_q <= reg_wdata; // [R11]
    end
  end

  ebbc_len_decode #(
    .CNT_W(EBBC_TX_CNT_W),
    .LEN_W(EBBC_TX_LEN_W),
    .FULL_LEN(EBBC_TX_FULL_LEN)
  ) u_tx_len (
    .full_flag(tx_count_q[EBBC_TX_FULL_BIT]),
    .count(tx_count_q[EBBC_TX_CNT_W-1:0]),
    .length(tx_len_d)
  );

  ebbc_len_decode #(
    .CNT_W(EBBC_BUF_CNT_W),
    .LEN_W(EBBC_BUF_LEN_W),
    .FULL_LEN(EBBC_BUF_FULL_LEN)
  ) u_rd_len (
    .full_flag(rd_high_q[EBBC_HIGH_FULL_BIT]),
    .count({rd_high_q[EBBC_HIGH_MSB_BIT], rd_low_q}),
    .length(rd_len_d)
  );

  // Transmit length frozen at the start pulse so a later rewrite of the
  // count cannot change a packet already under way
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ep_one_tx_start <= 1'b0;
      ep_one_tx_len <= '0;
    end else begin
      ep_one_tx_start <= ep_one_tx_go; // [R3]
      if (ep_one_tx_go) begin
        ep_one_tx_len <= tx_len_d; // [R1] [R2] [R3]
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_a_rd_len <= '0;
    end else begin
      buf_a_rd_len <= rd_len_d; // [R9] [R10] [R11] [R12]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ep_one_tx_base <= 16'h0000;
      buf_a_rd_base <= 16'h0000;
    end else begin
      ep_one_tx_base <= EBBC_EP_ONE_TX_BASE; // [R1]
      buf_a_rd_base <= EBBC_BUF_A_BASE; // [R11]
    end
  end

  // Unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      EBBC_OFS_EP_ONE_TX_COUNT: rdata_d = tx_count_q; // [R4]
      EBBC_OFS_A_WR_HIGH: rdata_d = cnt_u[0].high; // [R5] [R6]
      EBBC_OFS_A_WR_LOW: rdata_d = cnt_u[0].low; // [R7]
      EBBC_OFS_B_WR_HIGH: rdata_d = cnt_u[1].high; // [R5] [R6]
      EBBC_OFS_B_WR_LOW: rdata_d = cnt_u[1].low; // [R8]
      EBBC_OFS_A_RD_HIGH: rdata_d = rd_high_q; // [R4]
      EBBC_OFS_A_RD_LOW: rdata_d = rd_low_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : ebbc_top

// file: ebbc_props.sv
/* Port checker for ebbc_top.
   Assumes one clock and the bind in the bench. */
module ebbc_props
  import ebbc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ep_one_tx_go,
  input wire logic ep_one_tx_start,
  input wire logic [EBBC_TX_LEN_W-1:0] ep_one_tx_len,
  input wire logic [15:0] ep_one_tx_base,
  input wire logic buf_a_wr_done,
  input wire logic [EBBC_BUF_LEN_W-1:0] buf_a_wr_bytes,
  input wire logic [EBBC_BUF_LEN_W-1:0] buf_a_rd_len,
  input wire logic [15:0] buf_a_rd_base
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_full_wr;
    reg_wr && reg_addr == 8'hd3 && reg_wdata[1] ##1 !(reg_wr && reg_addr == 8'hd3);
  endsequence
  sequence s_a_hi;
    buf_a_wr_done ##2 (reg_rd && reg_addr == 8'hce);
  endsequence
  property p_start; ep_one_tx_go |=> ep_one_tx_start; endproperty
  a_start: assert property (p_start) else $error("no start pulse");
  property p_start_src; ep_one_tx_start |-> $past(ep_one_tx_go); endproperty
  a_start_src: assert property (p_start_src) else $error("stray start");
  property p_len_hold; !$past(ep_one_tx_go) |-> $stable(ep_one_tx_len); endproperty
  a_len_hold: assert property (p_len_hold) else $error("length moved");
  property p_len_max; ep_one_tx_len <= 7'h40; endproperty
  a_len_max: assert property (p_len_max) else $error("length above 64");
  property p_base; $past(reset_n) |-> ep_one_tx_base == 16'h00c0 && buf_a_rd_base == 16'h0100; endproperty
  a_base: assert property (p_base) else $error("bad base");
  property p_rsv_tx; reg_rd && reg_addr == 8'hc7 |=> !reg_rdata[7]; endproperty
  a_rsv_tx: assert property (p_rsv_tx) else $error("bit 7 set");
  property p_rsv_hi; reg_rd && reg_addr inside {8'hce, 8'hd1, 8'hd3} |=> reg_rdata[7:2] == 6'h00; endproperty
  a_rsv_hi: assert property (p_rsv_hi) else $error("high bits set");
  property p_rd_full; s_full_wr |=> buf_a_rd_len == 10'h200; endproperty
  a_rd_full: assert property (p_rd_full) else $error("not 512");
  property p_wr_hi;
    s_a_hi |=> reg_rdata[1:0] == {$past(buf_a_wr_bytes, 3) == 10'h200, $past(buf_a_wr_bytes[8], 3)};
  endproperty
  a_wr_hi: assert property (p_wr_hi) else $error("bad write high");
  // Read data stands only in the slot after a read strobe
  property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its slot");
endmodule // ebbc_props

// file: ebbc_top_tb.sv
/* Bench for ebbc_top: register port tasks and engine pulses.
   Assumes the checker in ebbc_props.sv. */
module ebbc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ep_one_tx_go = 1'b0, ep_one_tx_start;
  logic buf_a_wr_done = 1'b0, buf_b_wr_done = 1'b0;
  logic [9:0] buf_a_wr_bytes = 10'h000, buf_b_wr_bytes = 10'h000, buf_a_rd_len;
  logic [6:0] ep_one_tx_len;
  logic [15:0] ep_one_tx_base, buf_a_rd_base;
  int bad_count = 0;
  int n_tests = 0;
  logic [7:0] offs [7] = '{8'hc7, 8'hce, 8'hcf, 8'hd1, 8'hd2, 8'hd3, 8'hd4};
  logic [7:0] txv [5] = '{8'h05, 8'h3f, 8'h40, 8'hff, 8'h00};
  logic [9:0] wv [4] = '{10'h200, 10'h1ff, 10'h0a5, 10'h100};
  always #2 clk = ~clk;
  ebbc_top uut (.*);
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %0t seen %h want %h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(reg_rdata, e);
  endtask
  task rl(input logic [7:0] h, input logic [7:0] l, input logic [9:0] e);
    bus(1'b1, 8'hd4, l);
    bus(1'b1, 8'hd3, h);
    @(posedge clk);
    #1;
    chk(buf_a_rd_len, e);
  endtask
  task wc(input logic b, input logic [9:0] n);
    @(posedge clk);
    buf_a_wr_done <= !b;
    buf_b_wr_done <= b;
    buf_a_wr_bytes <= n;
    buf_b_wr_bytes <= n;
    @(posedge clk);
    buf_a_wr_done <= 1'b0;
    buf_b_wr_done <= 1'b0;
    rd(b ? 8'hd1 : 8'hce, {6'h00, n == 10'h200, n[8]});
    rd(b ? 8'hd2 : 8'hcf, n[7:0]);
  endtask
  task wrap_up;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    foreach (offs[i]) rd(offs[i], 8'h00);
    rd(8'h00, 8'h00);
    bus(1'b1, 8'hc7, 8'hff);
    rd(8'hc7, 8'h7f);
    bus(1'b1, 8'hd3, 8'hff);
    rd(8'hd3, 8'h03);
    bus(1'b1, 8'hce, 8'hff);
    rd(8'hce, 8'h00);
    chk(ep_one_tx_base, 16'h00c0);
    chk(buf_a_rd_base, 16'h0100);
    chk(buf_a_rd_len, 10'h200);
    foreach (txv[i]) begin
      bus(1'b1, 8'hc7, txv[i]);
      @(posedge clk);
      ep_one_tx_go <= 1'b1;
      @(posedge clk);
      ep_one_tx_go <= 1'b0;
      #1;
      chk(ep_one_tx_start, 1'b1);
      chk(ep_one_tx_len, txv[i][6] ? 7'h40 : {1'b0, txv[i][5:0]});
      @(posedge clk);
      #1;
      chk(ep_one_tx_start, 1'b0);
    end
    rl(8'h01, 8'h10, 10'h110);
    rl(8'h02, 8'hff, 10'h200);
    rl(8'h00, 8'hff, 10'h0ff);
    rd(8'hd4, 8'hff);
    foreach (wv[i]) begin
      wc(1'b0, wv[i]);
      wc(1'b1, wv[i]);
    end
    // Mid-run reset: outputs and registers must fall back to zero
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(ep_one_tx_base, 16'h0000);
    chk(buf_a_rd_base, 16'h0000);
    chk(buf_a_rd_len, 10'h000);
    chk(ep_one_tx_start, 1'b0);
    @(posedge clk);
    reset_n <= 1'b1;
    foreach (offs[i]) rd(offs[i], 8'h00);
    chk(ep_one_tx_base, 16'h00c0);
    chk(buf_a_rd_base, 16'h0100);
    wrap_up;
  end
endmodule // ebbc_top_tb
bind ebbc_top ebbc_props u_props (.*);
